// *** verilog/ispv_controller.sv ***
// Summary of operation
// - pin sense: low level, or falling edge
// - seven external plus 27 internal sources
// - only nonmaskable and pins 0-2 wake
// - nonmaskable highest, ignores both mask bits
// - nonmaskable edge polarity selectable
// - nonmaskable request gives vector 7
// - per-pin enable blocks disabled pins
// - four level bits for six pins
// - readable per-pin flag, software clearable
// - pins 0-5 map to vectors 12-17
// - detection uses pin level, any direction
// - internal request needs its enable bit
// - lower vector wins; default after reset
// - all but nonmaskable raisable to high
// - vector address: number times four/two
// - fixed internal vectors, reserved never issued
// - internal level bits shared per group
// - flag set on low or falling edge
// - write 1 ignored; read-1-write-0 clears
// - low level masked when primary mask set
// - high masked by primary alone in user mode, else both masks
module ispv_controller
  import ispv_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic [ADDR_W-1:0]    regAddr,
  input  wire logic [DATA_W-1:0]    regWrData,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [DATA_W-1:0]    regRdData,
  input  wire logic                 nmiPin,
  input  wire logic [5:0]           pinReq_n,
  input  wire logic [INT_COUNT-1:0] periphFlag,
  input  wire logic [INT_COUNT-1:0] periphEnable,
  input  wire logic                 cpuMaskPrimary,
  input  wire logic                 cpuMaskUser,
  input  wire logic                 modeAdvanced,
  input  wire logic                 inStandby,
  input  wire logic                 intAck,
  output logic                      irqPending,
  output logic      [5:0]           vectorNum,
  output logic      [15:0]          vectorAddr,
  output logic                      wakeReq
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  senseSel_reg,  senseSel_next;
  logic [7:0]  enable_reg,    enable_next;
  logic [7:0]  priA_reg,      priA_next;
  logic [7:0]  priB_reg,      priB_next;
  logic [7:0]  sysCtl_reg,    sysCtl_next;
  logic [5:0]  readSeen_reg,  readSeen_next;
  logic [7:0]  rdData_reg,    rdData_next;
  logic        nmiPrev_reg,   nmiPrev_next;
  logic        nmiLatch_reg,  nmiLatch_next;
  logic        pending_reg,   pending_next;
  logic [5:0]  vecNum_reg,    vecNum_next;
  logic [15:0] vecAddr_reg,   vecAddr_next;
  logic        wake_reg,      wake_next;
  logic [5:0]  pinFlag;
  logic [5:0]  swClear;
  logic [5:0]  ackClear;
  logic        nmiEdge;
  logic [63:0] reqVec;
  logic [63:0] hiVec;
  logic [63:0] hiCand;
  logic [63:0] loCand;
  logic        maskLow;
  logic        maskHigh;

  // lowest set index of a request vector
  function automatic logic [5:0] firstSet(input logic [63:0] r);
    logic [5:0] idx;
    idx = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (r[i]) begin
        idx = 6'(i);
      end
    end
    return idx;
  endfunction

  // ****************************************************************
  // pin request flags
  // ****************************************************************
  ispv_pin_detect u_pins (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .pinLevel_n (pinReq_n),
    .senseEdge  (senseSel_reg[5:0]),
    .swClear    (swClear),
    .ackClear   (ackClear),
    .flag       (pinFlag)
  );

  // ****************************************************************
  // register port
  // ****************************************************************
  always_comb begin
    senseSel_next = senseSel_reg;
    enable_next   = enable_reg;
    priA_next     = priA_reg;
    priB_next     = priB_reg;
    sysCtl_next   = sysCtl_reg;
    readSeen_next = readSeen_reg;
    rdData_next   = 8'h00;
    swClear       = PIN_NONE;
    if (regRead) begin
      unique case (regAddr)
        SENSE_OFS:  rdData_next = senseSel_reg;
        ENABLE_OFS: rdData_next = enable_reg;
        FLAG_OFS: begin
          rdData_next   = {2'b00, pinFlag};
          readSeen_next = readSeen_reg | pinFlag;
        end
        PRIA_OFS:   rdData_next = priA_reg;
        PRIB_OFS:   rdData_next = priB_reg;
        SYSCTL_OFS: rdData_next = sysCtl_reg & SYSCTL_MASK;
        default:    rdData_next = 8'h00;
      endcase
    end
    if (regWrite) begin
      unique case (regAddr)
        SENSE_OFS:  senseSel_next = regWrData;
        ENABLE_OFS: enable_next   = regWrData;
        FLAG_OFS: begin
          // ones are ignored; zero clears only a flag seen as one
          swClear       = readSeen_reg & ~regWrData[5:0];
          readSeen_next = readSeen_reg & regWrData[5:0];
        end
        PRIA_OFS:   priA_next   = regWrData;
        PRIB_OFS:   priB_next   = regWrData;
        SYSCTL_OFS: sysCtl_next = regWrData & SYSCTL_MASK;
        default:    ;
      endcase
    end
  end

  // ****************************************************************
  // request gathering and arbitration
  // ****************************************************************
  always_comb begin
    nmiPrev_next = nmiPin;
    nmiEdge = sysCtl_reg[EDGE_SEL_BIT] ? (nmiPin & ~nmiPrev_reg)
                                       : (~nmiPin & nmiPrev_reg);
    reqVec = 64'h0000_0000_0000_0000;
    hiVec  = 64'h0000_0000_0000_0000;
    for (int p = 0; p < PIN_COUNT; p++) begin
      reqVec[VEC_PIN0 + 6'(p)] = pinFlag[p] & enable_reg[p];
    end
    for (int s = 0; s < INT_COUNT; s++) begin
      reqVec[INT_VEC[s]] = periphFlag[s] & periphEnable[s];
    end
    for (int v = 0; v < 64; v++) begin
      hiVec[v] = ispvHighLevel(6'(v), priA_reg, priB_reg);
    end
    maskLow  = cpuMaskPrimary;
    maskHigh = sysCtl_reg[USER_MODE_BIT] ? cpuMaskPrimary
             : (cpuMaskPrimary & cpuMaskUser);
    hiCand = reqVec & hiVec & {64{~maskHigh}};
    loCand = reqVec & ~hiVec & {64{~maskLow}};

    // nonmaskable held until the core takes it
    nmiLatch_next = nmiLatch_reg;
    ackClear      = PIN_NONE;
    if (intAck && pending_reg) begin
      if (vecNum_reg == VEC_NMI) begin
        nmiLatch_next = 1'b0;
      end
      for (int p = 0; p < PIN_COUNT; p++) begin
        ackClear[p] = senseSel_reg[p] && (vecNum_reg == VEC_PIN0 + 6'(p));
      end
    end
    if (nmiEdge) begin
      nmiLatch_next = 1'b1;
    end

    // nonmaskable first, then high group, then low, lowest vector first
    pending_next = 1'b1;
    if (nmiLatch_reg) begin
      vecNum_next = VEC_NMI;
    end else if (|hiCand) begin
      vecNum_next = firstSet(hiCand);
    end else if (|loCand) begin
      vecNum_next = firstSet(loCand);
    end else begin
      vecNum_next  = vecNum_reg;
      pending_next = 1'b0;
    end
    vecAddr_next = modeAdvanced ? {8'h00, vecNum_next, 2'b00}
                                : {9'h000, vecNum_next, 1'b0};

    wake_next = inStandby
              & (nmiEdge | (|(pinFlag & enable_reg[5:0] & WAKE_PINS)));
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      senseSel_reg <= SENSE_RST;
      enable_reg   <= ENABLE_RST;
      priA_reg     <= PRIA_RST;
      priB_reg     <= PRIB_RST;
      sysCtl_reg   <= SYSCTL_RST;
      readSeen_reg <= PIN_NONE;
      rdData_reg   <= 8'h00;
      nmiPrev_reg  <= 1'b0;
      nmiLatch_reg <= 1'b0;
      pending_reg  <= 1'b0;
      vecNum_reg   <= 6'h00;
      vecAddr_reg  <= 16'h0000;
      wake_reg     <= 1'b0;
    end else begin
      senseSel_reg <= senseSel_next;
      enable_reg   <= enable_next;
      priA_reg     <= priA_next;
      priB_reg     <= priB_next;
      sysCtl_reg   <= sysCtl_next;
      readSeen_reg <= readSeen_next;
      rdData_reg   <= rdData_next;
      nmiPrev_reg  <= nmiPrev_next;
      nmiLatch_reg <= nmiLatch_next;
      pending_reg  <= pending_next;
      vecNum_reg   <= vecNum_next;
      vecAddr_reg  <= vecAddr_next;
      wake_reg     <= wake_next;
    end
  end

  assign regRdData  = rdData_reg;
  assign irqPending = pending_reg;
  assign vectorNum  = vecNum_reg;
  assign vectorAddr = vecAddr_reg;
  assign wakeReq    = wake_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_nmi_first_vector : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    nmiLatch_reg |=> pending_reg && vecNum_reg == 6'd7)
    else $error("latched nonmaskable not presented as vector 7");

  a_nmi_ignores_masks : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    nmiEdge && cpuMaskPrimary && cpuMaskUser ##1 1'b1 |=> pending_reg)
    else $error("nonmaskable blocked by cpu masks");

  a_disabled_pin : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    pending_reg && vecNum_reg == 6'd12 |-> $past(enable_reg[0]))
    else $error("disabled pin 0 forwarded a request");

  a_low_masked : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    pending_reg && vecNum_reg != 6'd7
      && !ispvHighLevel(vecNum_reg, $past(priA_reg), $past(priB_reg))
      |-> !$past(cpuMaskPrimary))
    else $error("low level request passed primary mask");

  a_high_masked : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    pending_reg && vecNum_reg != 6'd7 && $past(cpuMaskPrimary)
      |-> !$past(cpuMaskUser) && !$past(sysCtl_reg[USER_MODE_BIT]))
    else $error("request passed both masks");

  a_vector_address : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    pending_reg |-> vecAddr_reg == ($past(modeAdvanced)
      ? {8'h00, vecNum_reg, 2'b00} : {9'h000, vecNum_reg, 1'b0}))
    else $error("vector address does not match number");

  a_no_reserved : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    pending_reg |-> !(vecNum_reg inside {[6'd0:6'd6], [6'd8:6'd11],
      6'd18, 6'd19, 6'd21, 6'd22, 6'd27, 6'd31, 6'd35, [6'd44:6'd51],
      [6'd60:6'd63]}))
    else $error("reserved vector issued");

  a_wake_sources : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    wake_reg |-> $past(nmiEdge) || ($past(pinFlag[2:0]) != 3'b000))
    else $error("wake raised by a pin that cannot wake");

  a_flag_write_one : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    regWrite && regAddr == FLAG_OFS && regWrData[1] && pinFlag[1]
      && !ackClear[1] |=> pinFlag[1])
    else $error("writing one cleared a pin flag");

endmodule // ispv_controller

// *** shared/ispv_pkg.sv ***
package ispv_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W        = 3;
  localparam int          DATA_W        = 8;
  localparam logic [2:0]  SENSE_OFS     = 3'h0;
  localparam logic [2:0]  ENABLE_OFS    = 3'h1;
  localparam logic [2:0]  FLAG_OFS      = 3'h2;
  localparam logic [2:0]  PRIA_OFS      = 3'h3;
  localparam logic [2:0]  PRIB_OFS      = 3'h4;
  localparam logic [2:0]  SYSCTL_OFS    = 3'h5;

  localparam logic [7:0]  SENSE_RST     = 8'h00;
  localparam logic [7:0]  ENABLE_RST    = 8'h00;
  localparam logic [7:0]  PRIA_RST      = 8'h00;
  localparam logic [7:0]  PRIB_RST      = 8'h00;
  localparam logic [7:0]  SYSCTL_RST    = 8'h08;
  localparam logic [7:0]  FLAG_MASK     = 8'h3F;
  localparam logic [7:0]  SYSCTL_MASK   = 8'h0C;
  localparam int          EDGE_SEL_BIT  = 2;
  localparam int          USER_MODE_BIT = 3;

  // ****************************************************************
  // pins and vectors
  // ****************************************************************
  localparam int          PIN_COUNT     = 6;
  localparam int          INT_COUNT     = 27;
  localparam logic [5:0]  PIN_IDLE      = 6'h3F;
  localparam logic [5:0]  PIN_NONE      = 6'h00;
  localparam logic [5:0]  WAKE_PINS     = 6'h07;
  localparam logic [5:0]  VEC_NMI       = 6'h07;
  localparam logic [5:0]  VEC_PIN0      = 6'h0C;

  // vector of each internal source, index 0 upward
  localparam logic [5:0] INT_VEC [INT_COUNT] = '{
    6'h14, 6'h17,                                    // watchdog, converter
    6'h18, 6'h19, 6'h1A, 6'h1C, 6'h1D, 6'h1E,        // 16-bit ch0, ch1
    6'h20, 6'h21, 6'h22,                             // 16-bit ch2
    6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2A, 6'h2B, // 8-bit
    6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39, 6'h3A, 6'h3B  // serial
  };

  // priority group of a vector
  function automatic logic ispvHighLevel(input logic [5:0] vec,
                                         input logic [7:0] priA,
                                         input logic [7:0] priB);
    logic hi;
    hi = 1'b0;
    case (vec) inside
      6'd12:             hi = priA[7];
      6'd13:             hi = priA[6];
      [6'd14:6'd15]:     hi = priA[5];
      [6'd16:6'd17]:     hi = priA[4];
      6'd20, 6'd23:      hi = priA[3];
      [6'd24:6'd26]:     hi = priA[2];
      [6'd28:6'd30]:     hi = priA[1];
      [6'd32:6'd34]:     hi = priA[0];
      [6'd36:6'd39]:     hi = priB[7];
      [6'd40:6'd43]:     hi = priB[6];
      [6'd52:6'd55]:     hi = priB[3];
      [6'd56:6'd59]:     hi = priB[2];
      default:           hi = 1'b0;
    endcase
    return hi;
  endfunction

endpackage

// *** verilog/ispv_pin_detect.sv ***
module ispv_pin_detect
  import ispv_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [5:0]       pinLevel_n,
  input  wire logic [5:0]       senseEdge,
  input  wire logic [5:0]       swClear,
  input  wire logic [5:0]       ackClear,
  output logic      [5:0]       flag
);

  logic [5:0] prevLevel_reg;
  logic [5:0] prevLevel_next;
  logic [5:0] flag_reg;
  logic [5:0] flag_next;
  logic [5:0] setEvent;

  // ****************************************************************
  // request sensing
  // ****************************************************************
  always_comb begin
    // pin level taken whatever the pin direction
    setEvent = (senseEdge & prevLevel_reg & ~pinLevel_n)
             | (~senseEdge & ~pinLevel_n);
    // a new request beats a clear in the same cycle
    flag_next = (flag_reg & ~(swClear | ackClear)) | setEvent;
    prevLevel_next = pinLevel_n;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag_reg      <= PIN_NONE;
      prevLevel_reg <= PIN_IDLE;
    end else begin
      flag_reg      <= flag_next;
      prevLevel_reg <= prevLevel_next;
    end
  end

  assign flag = flag_reg;

  a_edge_flag_set : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    senseEdge[1] && prevLevel_reg[1] && !pinLevel_n[1] |=> flag_reg[1])
    else $error("falling edge did not set pin flag");

  a_level_flag_set : assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !senseEdge[0] && !pinLevel_n[0] |=> flag_reg[0])
    else $error("low level did not set pin flag");

endmodule // ispv_pin_detect

// *** verification/ispv_cpu_model.sv ***
module ispv_cpu_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       irqPending,
  input  wire logic [3:0] ackDelay,
  output logic            intAck
);
  timeunit 1ns;
  timeprecision 100ps;

  // ********
  // core side: takes a vector once it has stood ackDelay plus one cycles
  // ********
  logic [3:0] waitCnt;

  // one-cycle ack, only while a vector is presented
  always @(posedge core_clk) begin
    if (!rst_n || intAck || !irqPending) begin
      waitCnt <= 4'h0;
      intAck  <= 1'b0;
    end else if (waitCnt >= ackDelay) begin
      waitCnt <= 4'h0;
      intAck  <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule // ispv_cpu_model

// *** verification/ispv_controller_bench.sv ***
module ispv_controller_bench
  import ispv_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ********
  // signals
  // ********
  logic          core_clk, rst_n, regWrite, regRead, nmiPin, intAck;
  logic [2:0]    regAddr;
  logic [7:0]    regWrData, regRdData, pa, pb;
  logic [5:0]    pinReq_n, vectorNum, best;
  logic [26:0]   periphFlag, periphEnable, fl, en;
  logic          cpuMaskPrimary, cpuMaskUser, modeAdvanced, inStandby;
  logic          irqPending, wakeReq, bh, wk;
  logic [15:0]   vectorAddr;
  logic [3:0]    ackDelay;
  logic [31:0]   lfsr;
  logic          rdLive = 1'b0;
  logic [21:0]   rdQ[$], vecQ[$];
  logic [7:0]    rbk [8] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h0C,
                             8'h00, 8'h00};
  int            errCount = 0;
  int            testsRun = 0;
  int            b;

  ispv_controller u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .nmiPin(nmiPin), .pinReq_n(pinReq_n),
    .periphFlag(periphFlag), .periphEnable(periphEnable),
    .cpuMaskPrimary(cpuMaskPrimary), .cpuMaskUser(cpuMaskUser),
    .modeAdvanced(modeAdvanced), .inStandby(inStandby), .intAck(intAck),
    .irqPending(irqPending), .vectorNum(vectorNum),
    .vectorAddr(vectorAddr), .wakeReq(wakeReq)
  );

  ispv_cpu_model u_cpu (
    .core_clk(core_clk), .rst_n(rst_n), .irqPending(irqPending),
    .ackDelay(ackDelay), .intAck(intAck)
  );

  // ********
  // tasks
  // ********
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // level bit of an internal vector, p = {priority A, priority B}
  function automatic logic hiOf(input int v, input logic [15:0] p);
    if (v < 24) return p[11];
    if (v < 36) return p[10 - (v - 24) / 4];
    if (v < 44) return p[7 - (v - 36) / 4];
    return p[3 - (v - 52) / 4];
  endfunction

  task automatic check(input logic [21:0] got, input logic [21:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge core_clk);
    regWrite  <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rdQ.push_back({14'h0, e});
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic expectVec(input logic [5:0] v);
    vecQ.push_back({v, modeAdvanced ? {8'h00, v, 2'b00} : {9'h000, v, 1'b0}});
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (vecQ.size() != 0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (vecQ.size() != 0) begin
      errCount++;
      $display("[FAIL] %0t vector never taken", $time);
      vecQ.delete();
    end
  endtask

  task automatic quiet();
    logic seen;
    seen = 1'b0;
    // first edge still shows the result of the old inputs
    @(posedge core_clk);
    repeat (6) begin
      @(posedge core_clk);
      seen = seen | irqPending;
    end
    check({21'h0, seen}, 22'h0);
  endtask

  task automatic testDone();
    $display("compares %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // results come off the queues as the outputs show them
  always @(posedge core_clk) begin
    if (rdLive) begin
      check({14'h0, regRdData}, rdQ.size() ? rdQ.pop_front() : 22'h3F_FFFF);
    end
    if (intAck === 1'b1) begin
      check({vectorNum, vectorAddr},
            vecQ.size() ? vecQ.pop_front() : 22'h3F_FFFF);
    end
    rdLive <= regRead;
  end

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    $display("[FAIL] %0t run too long", $time);
    testDone();
  end

  // ********
  // scenarios
  // ********
  initial begin
    {rst_n, regWrite, regRead, nmiPin, regAddr, regWrData} = '0;
    {cpuMaskPrimary, cpuMaskUser, modeAdvanced, inStandby} = '0;
    {periphFlag, periphEnable} = '0;
    pinReq_n = 6'h3F;
    ackDelay = 4'h4;
    lfsr = 32'hf91c_43ed;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) rd(i[2:0], (i == 5) ? SYSCTL_RST : 8'h00);
    for (int i = 0; i < 8; i++) wr(i[2:0], 8'hFF);
    for (int i = 0; i < 8; i++) rd(i[2:0], rbk[i]);
    // system control keeps user mode select set
    for (int i = 0; i < 5; i++) wr(i[2:0], 8'h00);
    for (int t = 0; t < 12; t++) begin
      lfsr = nxt(lfsr);
      pa = lfsr[7:0];
      pb = lfsr[15:8];
      b = lfsr[31:27] % 27;
      modeAdvanced <= lfsr[16];
      ackDelay <= 4'h4 + {1'b0, lfsr[19:17]};
      wr(PRIA_OFS, pa);
      wr(PRIB_OFS, pb);
      lfsr = nxt(lfsr);
      fl = lfsr[26:0] | (27'h1 << b);
      lfsr = nxt(lfsr);
      en = lfsr[26:0] | (27'h1 << b);
      best = 6'h3F;
      bh = 1'b0;
      for (int k = 0; k < INT_COUNT; k++) begin
        if (fl[k] && en[k] && (best == 6'h3F || (hiOf(INT_VEC[k], {pa, pb}) && !bh))) begin
          best = INT_VEC[k];
          bh = hiOf(INT_VEC[k], {pa, pb});
        end
      end
      periphFlag <= fl;
      periphEnable <= en;
      @(posedge core_clk);
      expectVec(best);
      drain();
      periphFlag <= '0;
      repeat (4) @(posedge core_clk);
    end
    wr(PRIB_OFS, 8'h00);
    wr(PRIA_OFS, 8'h04);
    periphEnable <= 27'h5;
    cpuMaskPrimary <= 1'b1;
    periphFlag <= 27'h5;
    quiet();
    cpuMaskUser <= 1'b1;
    wr(SYSCTL_OFS, 8'h00);
    quiet();
    cpuMaskUser <= 1'b0;
    expectVec(6'd24);
    drain();
    periphFlag <= 27'h1;
    quiet();
    cpuMaskPrimary <= 1'b0;
    expectVec(6'd20);
    drain();
    periphFlag <= '0;
    wr(SENSE_OFS, 8'h3F);
    wr(ENABLE_OFS, 8'h3F);
    inStandby <= 1'b1;
    for (int p = 0; p < 6; p++) begin
      pinReq_n <= ~(6'h01 << p);
      expectVec(VEC_PIN0 + p[5:0]);
      wk = 1'b0;
      repeat (8) begin
        @(posedge core_clk);
        wk = wk | wakeReq;
      end
      pinReq_n <= 6'h3F;
      check({21'h0, wk}, {21'h0, p < 3});
      drain();
    end
    wr(ENABLE_OFS, 8'h3E);
    pinReq_n <= 6'h3E;
    @(posedge core_clk);
    pinReq_n <= 6'h3F;
    quiet();
    rd(FLAG_OFS, 8'h01);
    wr(FLAG_OFS, 8'h00);
    rd(FLAG_OFS, 8'h00);
    wr(SENSE_OFS, 8'h00);
    wr(ENABLE_OFS, 8'h02);
    pinReq_n <= 6'h3D;
    expectVec(6'd13);
    drain();
    cpuMaskPrimary <= 1'b1;
    pinReq_n <= 6'h3F;
    rd(FLAG_OFS, 8'h02);
    wr(FLAG_OFS, 8'h02);
    rd(FLAG_OFS, 8'h02);
    wr(FLAG_OFS, 8'h00);
    rd(FLAG_OFS, 8'h00);
    cpuMaskPrimary <= 1'b0;
    quiet();
    cpuMaskPrimary <= 1'b1;
    cpuMaskUser <= 1'b1;
    nmiPin <= 1'b1;
    quiet();
    nmiPin <= 1'b0;
    expectVec(VEC_NMI);
    drain();
    wr(SYSCTL_OFS, 8'h04);
    cpuMaskPrimary <= 1'b0;
    periphEnable <= 27'h1;
    periphFlag <= 27'h1;
    nmiPin <= 1'b1;
    expectVec(VEC_NMI);
    expectVec(6'd20);
    drain();
    periphFlag <= '0;
    repeat (8) @(posedge core_clk);
    testDone();
  end
endmodule // ispv_controller_bench
